// ===== core/rcc_pkg.sv
// Constants, register map and types of the reset and configuration control.
// Assumes one 125 MHz clock and a 32-bit APB master.
//
// Behaviour
// RL1: Config word is 12 bits, 11:5 read zero
// RL2: Bit 4 picks master clear or digital pin
// RL3: Bit 3 low turns code protection on
// RL4: Bit 2 alone enables the watchdog
// RL5: Bit 1 low enables pin pull-up, pin-function only
// RL6: Bit 0 picks 8 MHz or 4 MHz
// RL7: Config word only via programming port
// RL8: Boot at last address, load trim, wrap
// RL9: Calibration location readable despite code protection
// RL10: Trim register write trims the oscillator
// RL11: Six reset kinds are told apart
// RL12: Sleep resets keep registers, except cause flags; pin wake from sleep resets them here
// RL13: Some registers keep contents across non-power-on resets
// RL14: Power-up sets latch; timer runs once clear high
// RL15: Long hold time only after power-up
// RL16: External source holds reset until supply good
// RL17: Watchdog counts its own oscillator
// RL18: Pin change or watchdog ends sleep
// RL19: Watchdog reset or wake clears timeout flag
// RL20: Power-down flag set on power-up, cleared by sleep
// RL21: Pin change in sleep sets wake flag
// RL22: Reset asserts at once, releases on clock

package rcc_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int DRT_POR_NS = 1125000;
  localparam int DRT_SHORT_NS = 10000;
  // Least times round up to whole cycles
  localparam int DRT_POR_CYCLES = (DRT_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DRT_SHORT_CYCLES = (DRT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DRT_W = 20;
  localparam int WDT_W = 16;

  // ==========================================================
  // Register map: printed offsets are indices, byte address is four times
  localparam int STATUS_IDX = 3;
  localparam int OSC_TRIM_IDX = 5;
  localparam logic [7:0] STATUS_ADDR = 8'(STATUS_IDX * 4);
  localparam logic [7:0] OSC_TRIM_ADDR = 8'(OSC_TRIM_IDX * 4);

  // ==========================================================
  // Status fields
  localparam int STAT_WAKE_BIT = 7;
  localparam int STAT_TO_BIT = 4;
  localparam int STAT_PD_BIT = 3;
  localparam logic [2:0] STAT_SW_RST = 3'h0;
  localparam logic [7:0] OSC_TRIM_RST = 8'hfe;

  // ==========================================================
  // Configuration word
  localparam int CFG_W = 12;
  localparam int CFG_PINFN_BIT = 4;
  localparam int CFG_CP_BIT = 3;
  localparam int CFG_WATCHDOG_ENABLE_BIT_BIT = 2;
  localparam int CFG_PU_BIT = 1;
  localparam int CFG_FREQ_BIT = 0;
  localparam logic [11:0] CFG_IMPL_MASK = 12'h01f;
  localparam logic [11:0] CFG_ERASED = 12'h01f;

  // ==========================================================
  // Boot addresses
  localparam logic [7:0] PC_LAST = 8'hff;
  localparam logic [7:0] PC_WRAP = 8'h00;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {RCC_RUN, RCC_SLEEP, RCC_TIMING} rcc_state_type;
  typedef enum logic [2:0] {
    RCC_CAUSE_POR, RCC_CAUSE_MASTER_CLEAR_N_RUN, RCC_CAUSE_MASTER_CLEAR_N_SLEEP,
    RCC_CAUSE_WDT_RUN, RCC_CAUSE_WDT_SLEEP, RCC_CAUSE_PIN_WAKE
  } rcc_cause_type;

endpackage : rcc_pkg

// ===== core/rcc_top.sv
// Reset sequencer, reset cause flags, oscillator trim and config word.
// Assumes APB on pclk; pins and watchdog oscillator are asynchronous,
// CPU and programming strobes are synchronous to pclk.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps

module rcc_top #(
  parameter int unsigned POR_HOLD_CYCLES = rcc_pkg::DRT_POR_CYCLES,
  parameter logic [15:0] WDT_TICKS = 16'h0012,
  parameter logic [7:0] CAL_WORD = 8'h80
) (
  // Clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous pins
  input wire logic shared_reset_pin,
  input wire logic [1:0] gp_pins,
  input wire logic watchdog_osc,
  // CPU strobes
  input wire logic sleep_req,
  input wire logic clr_wdt,
  input wire logic port_access,
  input wire logic wake_on_change_en,
  // Programming port
  input wire logic prog_mode,
  input wire logic prog_cfg_we,
  input wire logic [11:0] prog_cfg_wdata,
  output logic [11:0] prog_cfg_rdata,
  input wire logic prog_rd_req,
  input wire logic [7:0] prog_rd_addr,
  output logic prog_rd_allow,
  // Reset outputs
  output logic core_reset_n,
  output logic state_reset_n,
  output logic sleeping,
  output logic [2:0] reset_cause,
  output logic watchdog_timeout,
  // Boot
  output logic [7:0] boot_pc,
  output logic [7:0] boot_w,
  // Configuration outputs
  output logic [7:0] osc_trim,
  output logic osc_freq_sel,
  output logic code_protect_on,
  output logic watchdog_en,
  output logic reset_pin_pullup_en,
  output logic shared_reset_pin_in
);

  localparam int CW = rcc_pkg::DRT_W;

  // ==========================================================
  // Synchronisers
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic wd_s3;
  logic [4:0] next_sync1;
  logic [4:0] next_sync2;
  logic next_wd_s3;
  logic wd_tick;
  logic master_clear_n_eff;
  logic [2:0] pins_now;

  // Two flops per pin; wd_s3 only feeds the edge detector
  always_comb begin
    next_sync1 = {watchdog_osc, shared_reset_pin, gp_pins, 1'b0};
    next_sync2 = sync1;
    next_wd_s3 = sync2[4];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 5'h1e;
      sync2 <= 5'h1e;
      wd_s3 <= 1'b1;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      wd_s3 <= next_wd_s3;
    end
  end

  assign wd_tick = sync2[4] & ~wd_s3; // [RL17]
  assign pins_now = sync2[3:1];

  // ==========================================================
  // Configuration word
  logic [11:0] cfg;
  logic [11:0] next_cfg;
  logic [11:0] next_prog_cfg_rdata;
  logic next_prog_rd_allow;
  logic next_osc_freq_sel;
  logic next_code_protect_on;
  logic next_watchdog_en;
  logic next_pullup_en;

  // Reachable only from the programming port, never from APB
  always_comb begin
    next_cfg = cfg;
    if (prog_mode && prog_cfg_we) begin
      next_cfg = prog_cfg_wdata & rcc_pkg::CFG_IMPL_MASK; // [RL7] [RL1]
    end
    next_prog_cfg_rdata = prog_mode ? (cfg & rcc_pkg::CFG_IMPL_MASK) : 12'h000; // [RL7] [RL1]
    // Calibration word stays readable under protection
    next_prog_rd_allow = prog_rd_req &
      (cfg[rcc_pkg::CFG_CP_BIT] || (prog_rd_addr == rcc_pkg::PC_LAST)); // [RL9]
    next_osc_freq_sel = cfg[rcc_pkg::CFG_FREQ_BIT]; // [RL6]
    next_code_protect_on = ~cfg[rcc_pkg::CFG_CP_BIT]; // [RL3]
    next_watchdog_en = cfg[rcc_pkg::CFG_WATCHDOG_ENABLE_BIT_BIT]; // [RL4]
    next_pullup_en = cfg[rcc_pkg::CFG_PINFN_BIT] & ~cfg[rcc_pkg::CFG_PU_BIT]; // [RL5]
  end

  // Nonvolatile word: power-on reset stands in for the erased array
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= rcc_pkg::CFG_ERASED;
      prog_cfg_rdata <= 12'h000;
      prog_rd_allow <= 1'b0;
      osc_freq_sel <= 1'b0;
      code_protect_on <= 1'b0;
      watchdog_en <= 1'b0;
      reset_pin_pullup_en <= 1'b0;
      shared_reset_pin_in <= 1'b1;
    end else begin
      cfg <= next_cfg;
      prog_cfg_rdata <= next_prog_cfg_rdata;
      prog_rd_allow <= next_prog_rd_allow;
      osc_freq_sel <= next_osc_freq_sel;
      code_protect_on <= next_code_protect_on;
      watchdog_en <= next_watchdog_en;
      reset_pin_pullup_en <= next_pullup_en;
      shared_reset_pin_in <= sync2[3];
    end
  end

  // Pin as digital I/O ties master clear high
  assign master_clear_n_eff = cfg[rcc_pkg::CFG_PINFN_BIT] ? sync2[3] : 1'b1; // [RL2]

  // ==========================================================
  // Watchdog
  logic [15:0] wcnt;
  logic [15:0] next_wcnt;
  logic next_wdt_to;
  rcc_pkg::rcc_state_type state;

  // Counts only its own oscillator edges, so it runs through sleep
  always_comb begin
    next_wcnt = wcnt;
    next_wdt_to = 1'b0;
    if (!cfg[rcc_pkg::CFG_WATCHDOG_ENABLE_BIT_BIT] || clr_wdt || state == rcc_pkg::RCC_TIMING ||
        (state == rcc_pkg::RCC_RUN && sleep_req)) begin
      next_wcnt = 16'h0000; // [RL4]
    end else if (wd_tick) begin
      if (wcnt == WDT_TICKS - 16'h0001) begin
        next_wcnt = 16'h0000;
        next_wdt_to = 1'b1; // [RL17]
      end else begin
        next_wcnt = wcnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt <= 16'h0000;
      watchdog_timeout <= 1'b0;
    end else begin
      wcnt <= next_wcnt;
      watchdog_timeout <= next_wdt_to;
    end
  end

  // ==========================================================
  // Reset sequencer and cause flags
  rcc_pkg::rcc_state_type next_state;
  rcc_pkg::rcc_cause_type cause;
  rcc_pkg::rcc_cause_type next_cause;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [CW-1:0] limit;
  logic long_hold;
  logic next_long_hold;
  logic keep;
  logic next_keep;
  logic to_n;
  logic next_to_n;
  logic pd_n;
  logic next_pd_n;
  logic wake_f;
  logic next_wake_f;
  logic [2:0] pin_ref;
  logic [2:0] next_pin_ref;
  logic pin_change;
  logic [7:0] next_boot_pc;
  logic [7:0] next_boot_w;

  assign limit = long_hold ? CW'(POR_HOLD_CYCLES - 1) :
                             CW'(rcc_pkg::DRT_SHORT_CYCLES - 1); // [RL15]
  assign pin_change = wake_on_change_en && (pins_now != pin_ref); // [RL21]

  // Classify each source and start the hold timer
  always_comb begin
    next_state = state;
    next_cause = cause;
    next_cnt = cnt;
    next_long_hold = long_hold;
    next_keep = keep;
    next_to_n = to_n;
    next_pd_n = pd_n;
    next_wake_f = wake_f;
    next_pin_ref = port_access ? pins_now : pin_ref; // [RL21]
    unique case (state)
      rcc_pkg::RCC_RUN: begin
        if (!master_clear_n_eff) begin
          next_state = rcc_pkg::RCC_TIMING; // [RL11]
          next_cause = rcc_pkg::RCC_CAUSE_MASTER_CLEAR_N_RUN;
          next_keep = 1'b0;
          next_wake_f = 1'b0;
          next_cnt = '0;
        end else if (watchdog_timeout) begin
          next_state = rcc_pkg::RCC_TIMING; // [RL11]
          next_cause = rcc_pkg::RCC_CAUSE_WDT_RUN;
          next_keep = 1'b0;
          next_to_n = 1'b0; // [RL19]
          next_wake_f = 1'b0;
          next_cnt = '0;
        end else if (sleep_req) begin
          next_state = rcc_pkg::RCC_SLEEP;
          next_pd_n = 1'b0; // [RL20]
          next_to_n = 1'b1;
        end
      end
      rcc_pkg::RCC_SLEEP: begin
        // Master clear and watchdog resets in sleep keep registers; pin wake resets them
        if (!master_clear_n_eff) begin
          next_state = rcc_pkg::RCC_TIMING; // [RL11]
          next_cause = rcc_pkg::RCC_CAUSE_MASTER_CLEAR_N_SLEEP;
          next_keep = 1'b1; // [RL12]
          next_to_n = 1'b1;
          next_pd_n = 1'b0;
          next_wake_f = 1'b0;
          next_cnt = '0;
        end else if (watchdog_timeout) begin
          next_state = rcc_pkg::RCC_TIMING; // [RL18]
          next_cause = rcc_pkg::RCC_CAUSE_WDT_SLEEP;
          next_keep = 1'b1; // [RL12]
          next_to_n = 1'b0; // [RL19]
          next_pd_n = 1'b0;
          next_wake_f = 1'b0;
          next_cnt = '0;
        end else if (pin_change) begin
          next_state = rcc_pkg::RCC_TIMING; // [RL18]
          next_cause = rcc_pkg::RCC_CAUSE_PIN_WAKE;
          next_keep = 1'b0; // [RL12]
          next_to_n = 1'b1;
          next_pd_n = 1'b0;
          next_wake_f = 1'b1; // [RL21]
          next_cnt = '0;
        end
      end
      rcc_pkg::RCC_TIMING: begin
        // Timer waits for master clear high, restarts if it drops
        if (!master_clear_n_eff) begin
          next_cnt = '0; // [RL14]
        end else if (cnt >= limit) begin
          next_state = rcc_pkg::RCC_RUN; // [RL14]
          next_long_hold = 1'b0; // [RL15]
          next_cnt = '0;
        end else begin
          next_cnt = cnt + CW'(1);
        end
      end
    endcase
  end

  // Vector fetch loads trim into W and wraps PC in the same cycle
  always_comb begin
    next_boot_pc = boot_pc;
    next_boot_w = boot_w;
    if (next_state == rcc_pkg::RCC_TIMING) begin
      next_boot_pc = rcc_pkg::PC_LAST; // [RL8]
    end else if (state == rcc_pkg::RCC_RUN && boot_pc == rcc_pkg::PC_LAST) begin
      next_boot_pc = rcc_pkg::PC_WRAP; // [RL8]
      next_boot_w = CAL_WORD;
    end
  end

  // Power-on sets the latch asynchronously; release is clocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= rcc_pkg::RCC_TIMING; // [RL14]
      cause <= rcc_pkg::RCC_CAUSE_POR;
      cnt <= '0;
      long_hold <= 1'b1; // [RL15]
      keep <= 1'b0;
      to_n <= 1'b1;
      pd_n <= 1'b1; // [RL20]
      wake_f <= 1'b0;
      pin_ref <= 3'h0;
      core_reset_n <= 1'b0; // [RL22]
      state_reset_n <= 1'b0;
      sleeping <= 1'b0;
      reset_cause <= 3'h0;
      boot_pc <= rcc_pkg::PC_LAST;
      boot_w <= 8'h00;
    end else begin
      state <= next_state;
      cause <= next_cause;
      cnt <= next_cnt;
      long_hold <= next_long_hold;
      keep <= next_keep;
      to_n <= next_to_n;
      pd_n <= next_pd_n;
      wake_f <= next_wake_f;
      pin_ref <= next_pin_ref;
      core_reset_n <= (next_state != rcc_pkg::RCC_TIMING); // [RL22]
      state_reset_n <= !(next_state == rcc_pkg::RCC_TIMING && !next_keep); // [RL12]
      sleeping <= (next_state == rcc_pkg::RCC_SLEEP);
      reset_cause <= next_cause;
      boot_pc <= next_boot_pc;
      boot_w <= next_boot_w;
    end
  end

  // ==========================================================
  // APB slave, one wait state
  logic [2:0] stat_sw;
  logic [2:0] next_stat_sw;
  logic [7:0] next_osc_trim;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic hit_status;
  logic hit_trim;
  logic commit;
  logic [7:0] status_word;

  assign hit_status = (paddr == rcc_pkg::STATUS_ADDR);
  assign hit_trim = (paddr == rcc_pkg::OSC_TRIM_ADDR);
  assign commit = psel & penable & pready;
  assign status_word = {wake_f, 2'b00, to_n, pd_n, stat_sw}; // [RL11]

  // Writes land only at the edge that samples pready high
  always_comb begin
    next_pready = psel & penable & ~pready;
    next_pslverr = psel & penable & ~pready & ~(hit_status | hit_trim);
    next_prdata = 32'h0000_0000;
    next_stat_sw = stat_sw;
    next_osc_trim = osc_trim;
    if (psel && penable && !pready && !pwrite) begin
      if (hit_status) begin
        next_prdata = {24'h000000, status_word};
      end else if (hit_trim) begin
        next_prdata = {24'h000000, osc_trim};
      end
    end
    if (commit && pwrite && hit_status) begin
      next_stat_sw = pwdata[2:0]; // Cause flags are read-only
    end
    if (commit && pwrite && hit_trim) begin
      next_osc_trim = pwdata[7:0]; // [RL10]
    end
  end

  // Trim and scratch bits survive every reset but power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      stat_sw <= rcc_pkg::STAT_SW_RST;
      osc_trim <= rcc_pkg::OSC_TRIM_RST; // [RL13]
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      stat_sw <= next_stat_sw;
      osc_trim <= next_osc_trim; // [RL13]
    end
  end

endmodule : rcc_top

// ===== verif/rcc_checker.sv
// Concurrent checks on the ports of the reset and config control.
// Assumes one clock pclk and the active-low reset presetn.
`timescale 1ns/1ps

module rcc_checker #(
  parameter int unsigned POR_HOLD_CYCLES = 20
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Programming port
  input wire logic prog_rd_req,
  input wire logic [7:0] prog_rd_addr,
  input wire logic prog_rd_allow,
  input wire logic [11:0] prog_cfg_rdata,
  // Reset and config outputs
  input wire logic code_protect_on,
  input wire logic watchdog_en,
  input wire logic watchdog_timeout,
  input wire logic shared_reset_pin_in,
  input wire logic core_reset_n,
  input wire logic state_reset_n,
  input wire logic [2:0] reset_cause,
  input wire logic [7:0] boot_pc
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========
  // Hold counter
  // Pin-high cycles while held; saturates so long holds never wrap
  logic [11:0] hi_cnt;
  logic [11:0] next_hi_cnt;
  always_comb begin
    next_hi_cnt = hi_cnt;
    if (core_reset_n || !shared_reset_pin_in) next_hi_cnt = 12'h000;
    else if (hi_cnt != 12'hfff) next_hi_cnt = hi_cnt + 12'h001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_cnt <= 12'h000;
    else hi_cnt <= next_hi_cnt;
  end

  // ==========
  // Assertions
  pready_late_a: assert property (
    pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside second access cycle");
  unmapped_err_a: assert property (
    pready && paddr != 8'h0c && paddr != 8'h14 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  cfg_upper_a: assert property (prog_cfg_rdata[11:5] == 7'h00)
    else $error("config upper bits not zero");
  read_allow_a: assert property (
    $past(presetn) |-> prog_rd_allow == ($past(prog_rd_req) &&
    ($past(prog_rd_addr) == 8'hff || !$past(code_protect_on))))
    else $error("program read permission wrong");
  boot_vec_a: assert property (
    !core_reset_n && $past(!core_reset_n) |-> boot_pc == 8'hff)
    else $error("boot pc not at last address in reset");
  boot_wrap_a: assert property ($rose(core_reset_n) |-> ##[0:1] boot_pc == 8'h00)
    else $error("boot pc did not wrap");
  wdt_off_a: assert property (
    !watchdog_en && $past(!watchdog_en) |-> !watchdog_timeout)
    else $error("timeout with watchdog disabled");
  sleep_keep_a: assert property (
    !core_reset_n && (reset_cause == 3'h2 || reset_cause == 3'h4) |-> state_reset_n)
    else $error("state reset during sleep reset");
  hold_time_a: assert property (
    $rose(core_reset_n) |-> hi_cnt >= 12'(POR_HOLD_CYCLES - 2))
    else $error("reset released too early");
  por_held_a: assert property (
    $rose(presetn) |-> !core_reset_n && !state_reset_n)
    else $error("core not held after power-on");

  // Main scenarios reached
  cover property ($rose(core_reset_n) && reset_cause == 3'h5);
  cover property (pready && pslverr);
  cover property (prog_rd_allow && code_protect_on);
endmodule : rcc_checker

bind rcc_top rcc_checker #(.POR_HOLD_CYCLES(POR_HOLD_CYCLES)) u_rcc_checker (
  .pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
  .prog_rd_req, .prog_rd_addr, .prog_rd_allow, .prog_cfg_rdata, .code_protect_on,
  .watchdog_en, .watchdog_timeout, .shared_reset_pin_in, .core_reset_n,
  .state_reset_n, .reset_cause, .boot_pc);

// ===== verif/rcc_master_clear_n_src.sv
// External master clear source driving the shared reset pin.
// Assumes a pull-up on the pin, so a released pin reads high.
`timescale 1ns/1ps

module rcc_master_clear_n_src #(
  parameter int unsigned SETTLE = 3
) (
  // Clock and request
  input wire logic pclk,
  input wire logic hold_req,
  // Pin
  output logic shared_reset_pin
);
  int unsigned left;

  // Keep holding a few cycles after the request, supply may still settle
  always @(posedge pclk) begin
    if (hold_req) left <= SETTLE;
    else if (left != 0) left <= left - 1;
  end

  // Released pin goes to the pull-up level
  assign shared_reset_pin = (hold_req || left != 0) ? 1'b0 : 1'b1;
endmodule : rcc_master_clear_n_src

// ===== verif/rcc_top_test.sv
// Self-checking bench of the reset and config control.
// Assumes the checker is bound in and the pin model drives the reset pin.
`timescale 1ns/1ps

module rcc_top_test;
  localparam int HOLD = 20;
  localparam logic [7:0] CAL = 8'h80;
  localparam logic [15:0] CFG_TAB [3] = '{16'hfffa, 16'h01db, 16'h0004};
  localparam logic [2:0] ORD [5] = '{3'h1, 3'h3, 3'h2, 3'h4, 3'h5};
  localparam logic [7:0] ST [5] = '{8'h1f, 8'h0f, 8'h17, 8'h07, 8'h97};

  // Design inputs
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic watchdog_osc = 1'b0, sleep_req = 1'b0, clr_wdt = 1'b1, port_access = 1'b0;
  logic wake_on_change_en = 1'b0, prog_mode = 1'b0, prog_cfg_we = 1'b0;
  logic prog_rd_req = 1'b0, hold = 1'b1;
  logic [7:0] paddr = 8'h00, prog_rd_addr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [11:0] prog_cfg_wdata = 12'h000;
  logic [1:0] gp_pins = 2'b00;
  // Design outputs
  logic [31:0] prdata;
  logic [11:0] prog_cfg_rdata;
  logic [7:0] boot_pc, boot_w, osc_trim;
  logic [2:0] reset_cause;
  logic pready, pslverr, shared_reset_pin, prog_rd_allow, core_reset_n, state_reset_n;
  logic sleeping, watchdog_timeout, osc_freq_sel, code_protect_on, watchdog_en;
  logic reset_pin_pullup_en, shared_reset_pin_in;
  int err_count = 0;
  int n_checks = 0;

  // Clocks: watchdog oscillator unrelated to pclk
  always #4 pclk = ~pclk;
  always #37 watchdog_osc = ~watchdog_osc;

  rcc_top #(.POR_HOLD_CYCLES(HOLD), .WDT_TICKS(16'h0004), .CAL_WORD(CAL)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .shared_reset_pin, .gp_pins, .watchdog_osc, .sleep_req, .clr_wdt,
    .port_access, .wake_on_change_en, .prog_mode, .prog_cfg_we, .prog_cfg_wdata,
    .prog_cfg_rdata, .prog_rd_req, .prog_rd_addr, .prog_rd_allow, .core_reset_n,
    .state_reset_n, .sleeping, .reset_cause, .watchdog_timeout, .boot_pc, .boot_w,
    .osc_trim, .osc_freq_sel, .code_protect_on, .watchdog_en, .reset_pin_pullup_en,
    .shared_reset_pin_in);

  rcc_master_clear_n_src u_src (.pclk, .hold_req(hold), .shared_reset_pin);

  // ==========
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready, a spare edge keeps strobes apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && n++ < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk(e, a != 8'h0c && a != 8'h14);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic wait_core(input logic v, output int n);
    n = 0;
    while (core_reset_n !== v && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_core

  task automatic cfg_wr(input logic [11:0] v);
    prog_cfg_we <= 1'b1;
    prog_cfg_wdata <= v;
    @(posedge pclk);
    prog_cfg_we <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : cfg_wr

  // Raise one reset kind, then check cause, flags and boot
  task automatic cause(input logic [2:0] k, input logic [7:0] st);
    int n;
    logic slp;
    slp = k == 3'h2 || k >= 3'h4;
    port_access <= k == 3'h5;
    wake_on_change_en <= k == 3'h5;
    @(posedge pclk);
    port_access <= 1'b0;
    sleep_req <= slp;
    @(posedge pclk);
    sleep_req <= 1'b0;
    @(posedge pclk);
    chk(sleeping, slp);
    hold <= k <= 3'h2;
    clr_wdt <= !(k == 3'h3 || k == 3'h4);
    if (k == 3'h5) gp_pins <= ~gp_pins;
    wait_core(1'b0, n);
    hold <= 1'b0;
    clr_wdt <= 1'b1;
    wake_on_change_en <= 1'b0;
    chk(state_reset_n, k == 3'h2 || k == 3'h4);
    wait_core(1'b1, n);
    @(posedge pclk);
    chk(n >= 1250 && n <= 1265, 1'b1);
    chk(reset_cause, k);
    chk({boot_pc, boot_w}, {8'h00, CAL});
    rd(8'h0c, st);
    $display("Test cause %0d done", k);
  endtask : cause

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // ==========
  // Tests
  initial begin
    int n;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(core_reset_n, 1'b0);
    hold <= 1'b0;
    wait_core(1'b1, n);
    @(posedge pclk);
    chk(n >= HOLD && n <= HOLD + 8, 1'b1);
    chk({boot_pc, boot_w}, {8'h00, CAL});
    rd(8'h0c, 32'h18);
    rd(8'h14, 32'hfe);
    wr(8'h14, 32'h5a);
    rd(8'h14, 32'h5a);
    chk(osc_trim, 8'h5a);
    wr(8'h0c, 32'hff);
    rd(8'h0c, 32'h1f);
    rd(8'h00, 32'h0);
    $display("Test registers done");
    prog_mode <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      cfg_wr(CFG_TAB[i][15:4]);
      chk(prog_cfg_rdata, CFG_TAB[i][15:4] & 12'h01f);
      chk({osc_freq_sel, code_protect_on, watchdog_en, reset_pin_pullup_en},
          CFG_TAB[i][3:0]);
    end
    prog_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(prog_cfg_rdata, 12'h000);
    for (int j = 0; j < 2; j++) begin
      prog_rd_addr <= j ? 8'hff : 8'h10;
      prog_rd_req <= 1'b1;
      @(posedge pclk);
      prog_rd_req <= 1'b0;
      @(posedge pclk);
      chk(prog_rd_allow, j);
    end
    hold <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(core_reset_n, 1'b1);
    hold <= 1'b0;
    repeat (6) @(posedge pclk);
    prog_mode <= 1'b1;
    cfg_wr(12'h01f);
    prog_mode <= 1'b0;
    $display("Test config done");
    for (int i = 0; i < 5; i++) cause(ORD[i], ST[i]);
    give_verdict();
  end

  // Hang guard, well past the expected run of about 52 us
  initial begin
    #300us;
    err_count++;
    give_verdict();
  end
endmodule : rcc_top_test
